// *** bench/spfc_flow_ctrl_tb.sv ***
`timescale 1ns/1ps
`include "spfc_defs.vh"
module spfc_flow_ctrl_tb;
  reg         mclk_i = 1'b0;
  reg         reset_n_i = 1'b0;
  reg  [15:0] reg_addr_i = 16'h0000;
  reg  [15:0] reg_wdata_i = 16'h0000;
  reg         reg_wr_i = 1'b0;
  reg         reg_rd_i = 1'b0;
  reg  [7:0]  port_mode_i = 8'h00;
  reg  [3:0]  drv_mode_i = 4'h0;
  reg  [1:0]  tx_pending_i = 2'h0;
  reg  [1:0]  tx_idle_i = 2'h3;
  reg  [1:0]  rx_backlog_i = 2'h0;
  reg  [1:0]  char_tick_i = 2'h0;
  reg  [1:0]  reply_wait_i = 2'h0;
  reg  [1:0]  ack_rx_i = 2'h0;
  reg  [7:0]  route_len_i = 8'h00;
  reg  [1:0]  mb_master_i = 2'h0;
  reg  [1:0]  binary_framing_i = 2'h0;
  reg  [1:0]  data_bits8_i = 2'h3;
  reg         hold = 1'b0;
  wire [15:0] reg_rdata_o;
  wire [1:0]  cts_pin_i, rts_pin_o, tx_start_o, tx_oe_o, rx_en_o, pad_send_o, enq_send_o;
  wire [1:0]  route_ok_o, may_initiate_o, char_bits8_o;
  integer     n_fail = 0;
  integer     check_count = 0;
  integer     cyc = 0;
  integer     i, n, q;
  // Short tick keeps delay windows to tens of cycles
  spfc_flow_ctrl #(.TICK_CYCLES(10)) uut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .port_mode_i(port_mode_i),
    .drv_mode_i(drv_mode_i), .cts_pin_i(cts_pin_i), .rts_pin_o(rts_pin_o), .tx_pending_i(tx_pending_i),
    .tx_idle_i(tx_idle_i), .tx_start_o(tx_start_o), .tx_oe_o(tx_oe_o), .rx_en_o(rx_en_o),
    .rx_backlog_i(rx_backlog_i), .char_tick_i(char_tick_i), .reply_wait_i(reply_wait_i), .ack_rx_i(ack_rx_i),
    .pad_send_o(pad_send_o), .enq_send_o(enq_send_o), .route_len_i(route_len_i), .route_ok_o(route_ok_o),
    .mb_master_i(mb_master_i), .may_initiate_o(may_initiate_o), .binary_framing_i(binary_framing_i),
    .data_bits8_i(data_bits8_i), .char_bits8_o(char_bits8_o)
  );
  spfc_modem u_m1 (.mclk_i(mclk_i), .key_i(rts_pin_o[0]), .lag_i(4'h3), .hold_i(hold), .cts_o(cts_pin_i[0]));
  spfc_modem u_m2 (.mclk_i(mclk_i), .key_i(rts_pin_o[1]), .lag_i(4'h0), .hold_i(hold), .cts_o(cts_pin_i[1]));
  always #50 mclk_i = ~mclk_i;
  task give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  task tk;
    @(posedge mclk_i);
    #1;
  endtask
  task chk(input [15:0] s, input [15:0] e);
    check_count = check_count + 1;
    if (s !== e) begin
      n_fail = n_fail + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input [15:0] a, input [15:0] d);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    tk;
    reg_wr_i    = 1'b0;
  endtask
  task rd(input [15:0] a, input [15:0] e);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    tk;
    reg_rd_i   = 1'b0;
    chk(reg_rdata_o, e);
    tk;
  endtask
  // Pads counted in n, enq pulses in q
  task chr(input integer k);
    repeat (k) begin
      char_tick_i = 2'h1;
      tk;
      char_tick_i = 2'h0;
      n = n + pad_send_o[0];
      q = q + enq_send_o[0];
      tk;
    end
  endtask
  task wait_go;
    reply_wait_i = 2'h1;
    tk;
    reply_wait_i = 2'h0;
    n = 0;
    q = 0;
  endtask
  // Cycles from clear-to-send seen until grant
  task meas(input integer lo, input integer hi, input r);
    hold = 1'b1;
    repeat (10) tk;
    tx_pending_i = 2'h1;
    hold = 1'b0;
    for (i = 0; i < 60 && cts_pin_i[0] !== 1'b1; i = i + 1) tk;
    for (n = 0; n < 200 && tx_start_o[0] !== 1'b1; n = n + 1) tk;
    chk(n >= lo && n <= hi, 16'h0001);
    tx_pending_i = 2'h0;
    tx_idle_i = 2'h2;
    repeat (2) tk;
    chk(rts_pin_o[0], 1'b1);
    chk(rx_en_o[0], !drv_mode_i[1]);
    chk(tx_oe_o[0], 1'b1);
    tx_idle_i = 2'h3;
    repeat (2) tk;
    chk(rts_pin_o[0], r);
    repeat (12) tk;
  endtask
  initial begin
    repeat (20) tk;
    reset_n_i = 1'b1;
    rd(`SPFC_REG_P1_STAT, `SPFC_RST_STAT);
    rd(`SPFC_REG_P1_MDM_DLY, `SPFC_RST_MDM_DLY);
    rd(`SPFC_REG_P1_DLY_PAD, `SPFC_RST_DLY_PAD);
    rd(16'h0001, 16'h0000);
    wr(`SPFC_REG_P2_STAT, 16'h1234);
    rd(`SPFC_REG_P2_STAT, `SPFC_RST_STAT);
    wr(`SPFC_REG_P2_MDM_DLY, 16'ha5a5);
    rd(`SPFC_REG_P2_MDM_DLY, 16'ha5a5);
    wr(`SPFC_REG_P2_DLY_PAD, 16'h5a5a);
    rd(`SPFC_REG_P2_DLY_PAD, 16'h5a5a);
    wr(`SPFC_REG_P1_DLY_PAD, 16'h0003);
    wait_go;
    chr(10);
    chk(n, 10);
    chk(q, 0);
    chr(1);
    chk(q, 1);
    wr(`SPFC_REG_P1_DLY_PAD, 16'h000c);
    wait_go;
    chr(4);
    ack_rx_i = 2'h1;
    tk;
    ack_rx_i = 2'h0;
    rd(`SPFC_REG_P1_STAT, 16'h0004);
    wr(`SPFC_REG_P1_DLY_PAD, 16'h0004 + 16'h000a);
    rd(`SPFC_REG_P1_DLY_PAD, 16'h000e);
    for (i = 0; i < 11; i = i + 1) begin
      port_mode_i = {4'h0, i[3:0]};
      repeat (2) tk;
      chk(rts_pin_o[0], i < 6);
    end
    port_mode_i = 8'h00;
    rx_backlog_i = 2'h1;
    repeat (2) tk;
    chk(rts_pin_o[0], 1'b0);
    rx_backlog_i = 2'h0;
    repeat (12) tk;
    chk(rts_pin_o[0], 1'b1);
    drv_mode_i = 4'h1;
    hold = 1'b1;
    tx_pending_i = 2'h1;
    repeat (30) tk;
    chk(tx_start_o[0], 1'b0);
    chk(tx_oe_o[0], 1'b0);
    meas(3, 9, 1'b1);
    port_mode_i = 8'h66;
    wr(`SPFC_REG_P1_DLY_PAD, 16'h0002);
    meas(22, 38, 1'b0);
    port_mode_i = 8'haa;
    drv_mode_i = 4'h3;
    wr(`SPFC_REG_P1_MDM_DLY, 16'h0004);
    meas(42, 58, 1'b0);
    for (i = 0; i < 4; i = i + 1) begin
      route_len_i = 8'h77 + i[7:0];
      repeat (2) tk;
      chk(route_ok_o, {1'b1, i < 2});
    end
    port_mode_i = 8'h99;
    binary_framing_i = 2'h3;
    data_bits8_i = 2'h0;
    repeat (2) tk;
    chk(may_initiate_o, 2'h0);
    chk(char_bits8_o, 2'h3);
    mb_master_i = 2'h1;
    binary_framing_i = 2'h0;
    repeat (2) tk;
    chk(may_initiate_o, 2'h1);
    chk(char_bits8_o, 2'h0);
    give_verdict;
  end
endmodule

// *** bench/spfc_modem.sv ***
`timescale 1ns/1ps
module spfc_modem (
  input  wire       mclk_i,
  input  wire       key_i,
  input  wire [3:0] lag_i,
  input  wire       hold_i,
  output reg        cts_o
);
  reg [3:0] wait_r;
  initial begin
    wait_r = 4'h0;
    cts_o  = 1'b0;
  end
  // Hold restrains the port; bench always lets go in bounded time
  always @(posedge mclk_i) begin
    if (!key_i || hold_i) begin
      wait_r <= 4'h0;
      cts_o  <= 1'b0;
    end else if (wait_r >= lag_i) begin
      cts_o <= 1'b1; // Push to talk answered after lag
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// *** bench/spfc_properties.sv ***
`timescale 1ns/1ps
`include "spfc_defs.vh"
module spfc_props (
  input wire       mclk_i,
  input wire       reset_n_i,
  input wire [7:0] port_mode_i,
  input wire [3:0] drv_mode_i,
  input wire [1:0] cts_pin_i,
  input wire [1:0] rts_pin_o,
  input wire [1:0] tx_pending_i,
  input wire [1:0] tx_idle_i,
  input wire [1:0] tx_start_o,
  input wire [1:0] tx_oe_o,
  input wire [1:0] rx_backlog_i,
  input wire [1:0] char_tick_i,
  input wire [1:0] pad_send_o,
  input wire [1:0] enq_send_o,
  input wire [7:0] route_len_i,
  input wire [1:0] route_ok_o,
  input wire [1:0] mb_master_i,
  input wire [1:0] may_initiate_o,
  input wire [1:0] binary_framing_i,
  input wire [1:0] data_bits8_i,
  input wire [1:0] char_bits8_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  wire [3:0] md  = port_mode_i[3:0];
  wire       req = (md >= `SPFC_MODE_MULTIDROP) && (md <= `SPFC_MODE_RMODEM);
  wire       mb  = (md == `SPFC_MODE_MODBUS);
  // Eight cycles covers sync, ready and gate drop
  sequence s_cts_off;
    (!cts_pin_i[0] && tx_idle_i[0]) [*8];
  endsequence
  sequence s_cts_open;
    (drv_mode_i[0] && !cts_pin_i[0]) [*6];
  endsequence
  a_tx_gate: assert property (tx_start_o[0] |-> tx_pending_i[0] && tx_idle_i[0])
    else $error("start without pending and idle");
  a_cts_block: assert property (s_cts_off |-> !tx_start_o[0])
    else $error("start while clear-to-send low");
  a_rts_buffer: assert property ($past(reset_n_i) && !$past(req) |-> rts_pin_o[0] == !$past(rx_backlog_i[0]))
    else $error("rts not backlog inverse");
  a_rts_request: assert property ($past(reset_n_i) && $past(req)
    |-> rts_pin_o[0] == ($past(tx_pending_i[0]) || !$past(tx_idle_i[0])))
    else $error("rts not request form");
  a_oe_ptpt: assert property (drv_mode_i[1:0] == `SPFC_DRV_PT2PT |-> tx_oe_o[0])
    else $error("point mode driver off");
  a_oe_tristate: assert property (s_cts_open |-> !tx_oe_o[0])
    else $error("driver on without clear-to-send");
  a_pad_tick: assert property (pad_send_o[0] || enq_send_o[0] |-> $past(char_tick_i[0])
    && !(pad_send_o[0] && enq_send_o[0]))
    else $error("pad or enq off tick");
  a_route_limit: assert property ($past(reset_n_i) |-> route_ok_o[0] == ($past(route_len_i[3:0]) <= `SPFC_ROUTE_MAX))
    else $error("route limit wrong");
  a_may_init: assert property ($past(reset_n_i) |-> may_initiate_o[0] == (!$past(mb) || $past(mb_master_i[0])))
    else $error("initiate flag wrong");
  a_char_width: assert property ($past(reset_n_i) |-> char_bits8_o[0]
    == ($past(mb) ? $past(binary_framing_i[0]) : $past(data_bits8_i[0])))
    else $error("character width wrong");
endmodule
bind spfc_flow_ctrl spfc_props u_props (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .port_mode_i(port_mode_i), .drv_mode_i(drv_mode_i),
  .cts_pin_i(cts_pin_i), .rts_pin_o(rts_pin_o), .tx_pending_i(tx_pending_i), .tx_idle_i(tx_idle_i),
  .tx_start_o(tx_start_o), .tx_oe_o(tx_oe_o), .rx_backlog_i(rx_backlog_i), .char_tick_i(char_tick_i),
  .pad_send_o(pad_send_o), .enq_send_o(enq_send_o), .route_len_i(route_len_i), .route_ok_o(route_ok_o),
  .mb_master_i(mb_master_i), .may_initiate_o(may_initiate_o), .binary_framing_i(binary_framing_i),
  .data_bits8_i(data_bits8_i), .char_bits8_o(char_bits8_o)
);

// *** include/spfc_defs.vh ***
`ifndef SPFC_DEFS_VH
`define SPFC_DEFS_VH

// Register numbers (word addresses on the register port)
`define SPFC_REG_P1_STAT      16'h0818
`define SPFC_REG_P2_STAT      16'h0838
`define SPFC_REG_P1_MDM_DLY   16'h1f6a
`define SPFC_REG_P1_DLY_PAD   16'h1f80
`define SPFC_REG_P2_MDM_DLY   16'h1f8a
`define SPFC_REG_P2_DLY_PAD   16'h1fa0

// Reset values
`define SPFC_RST_MDM_DLY      16'h0000
`define SPFC_RST_DLY_PAD      16'h000a
`define SPFC_RST_STAT         16'h0000

// Pad count floor and route limit
`define SPFC_PAD_MIN          16'h000a
`define SPFC_ROUTE_MAX        4'h8

// Delay unit: 10 ms at 10 MHz
`define SPFC_DLY_UNIT_MS      10
`define SPFC_CLK_KHZ          10000

// Port modes
`define SPFC_MODE_PEER        4'h0
`define SPFC_MODE_NETLINK     4'h1
`define SPFC_MODE_PWRMTR      4'h2
`define SPFC_MODE_PLCLINK     4'h3
`define SPFC_MODE_GATEWAY     4'h4
`define SPFC_MODE_TRANSP      4'h5
`define SPFC_MODE_MULTIDROP   4'h6
`define SPFC_MODE_PERIPH      4'h7
`define SPFC_MODE_SHARE       4'h8
`define SPFC_MODE_MODBUS      4'h9
`define SPFC_MODE_RMODEM      4'ha

// Driver modes
`define SPFC_DRV_PT2PT        2'h0
`define SPFC_DRV_FOUR_WIRE    2'h1
`define SPFC_DRV_HALF_DUP     2'h2
`define SPFC_DRV_TWO_WIRE     2'h3

`endif

// *** logic/spfc_flow_ctrl.v ***
`timescale 1ns/1ps
`include "spfc_defs.vh"

// Functional notes
// R1: With clear-to-send active, a queued message is allowed to start transmitting.
// R2: With clear-to-send inactive or open, pending characters stay held, none sent.
// R3: Peripheral must not hold clear-to-send off forever; buffering is finite.
// R4: Request-style modes wait a delay, counted in 10 ms steps, after clear-to-send rises.
// R5: Remote-modem mode takes the delay from the per-port modem delay register.
// R6: Other request-style modes take the delay from the delay/pad register.
// R7: Buffer-style modes keep request-to-send active, dropping it only while backlogged.
// R8: Request-style modes raise request-to-send only while data waits or is sending.
// R9: Modem or radio keys on request-to-send and answers with clear-to-send.
// R10: Peer, network-link and power-meter modes send pads awaiting reply, then ENQ.
// R11: Pad count defaults to 10; any smaller value acts as 10.
// R12: Pad count comes from the per-port delay/pad register.
// R13: Bytes sent between checksum and acknowledge are kept in read-only statistics.
// R14: Configurer should set pad count to the statistic plus 10.
// R15: Direct route carries no drops; networked route names source then target ports.
// R16: Each extra hop adds a drop; route never exceeds 8 drops.
// R17: Only the single Modbus master starts transactions; slaves only answer.
// R18: ASCII framing uses 7-bit characters, binary framing 8-bit; never mixed.
// R19: Four-wire and two-wire driver modes tri-state transmitter without clear-to-send.
// R20: Clear-to-send is sampled only at character boundaries.
// R21: Each pad occupies one full character time at the port's line rate.
module spfc_flow_ctrl #(
  parameter TICK_CYCLES = `SPFC_DLY_UNIT_MS * `SPFC_CLK_KHZ
) (
  input  wire        mclk_i,
  input  wire        reset_n_i,
  input  wire [15:0] reg_addr_i,
  input  wire        reg_wr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        reg_rd_i,
  output reg  [15:0] reg_rdata_o,
  input  wire [7:0]  port_mode_i,
  input  wire [3:0]  drv_mode_i,
  input  wire [1:0]  cts_pin_i,
  output wire [1:0]  rts_pin_o,
  input  wire [1:0]  tx_pending_i,
  input  wire [1:0]  tx_idle_i,
  output wire [1:0]  tx_start_o,
  output wire [1:0]  tx_oe_o,
  output wire [1:0]  rx_en_o,
  input  wire [1:0]  rx_backlog_i,
  input  wire [1:0]  char_tick_i,
  input  wire [1:0]  reply_wait_i,
  input  wire [1:0]  ack_rx_i,
  output wire [1:0]  pad_send_o,
  output wire [1:0]  enq_send_o,
  input  wire [7:0]  route_len_i,
  output wire [1:0]  route_ok_o,
  input  wire [1:0]  mb_master_i,
  output wire [1:0]  may_initiate_o,
  input  wire [1:0]  binary_framing_i,
  input  wire [1:0]  data_bits8_i,
  output wire [1:0]  char_bits8_o
);

  localparam PAD_IDLE = 1'b0;
  localparam PAD_WAIT = 1'b1;

  // Shared 10 ms tick; one divider serves both ports
  reg  [16:0] tick_cnt_r;
  wire        tick_w;

  assign tick_w = (tick_cnt_r == TICK_CYCLES[16:0] - 17'h00001);

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tick_cnt_r <= 17'h00000;
    end else if (tick_w) begin
      tick_cnt_r <= 17'h00000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h00001;
    end
  end

  wire [15:0] mdm_dly_w [0:1];
  wire [15:0] dly_pad_w [0:1];
  wire [15:0] stat_w    [0:1];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : port
      wire [15:0] a_mdm  = (g == 0) ? `SPFC_REG_P1_MDM_DLY : `SPFC_REG_P2_MDM_DLY;
      wire [15:0] a_pad  = (g == 0) ? `SPFC_REG_P1_DLY_PAD : `SPFC_REG_P2_DLY_PAD;
      wire [3:0]  mode   = port_mode_i[4*g+3:4*g];
      wire [1:0]  drv    = drv_mode_i[2*g+1:2*g];

      reg  [15:0] mdm_dly_r;
      reg  [15:0] dly_pad_r;
      reg  [15:0] stat_r;
      reg         cts_s1_r;
      reg         cts_s2_r;
      reg         cts_s3_r;
      reg         cts_lvl_r;
      reg  [16:0] dly_cnt_r;
      reg         req_mode_d_r;
      reg         cts_ready_r;
      reg         tx_en_r;
      reg         rts_r;
      reg         pad_st_r;
      reg  [15:0] pad_cnt_r;
      reg         pad_r;
      reg         enq_r;
      reg         route_ok_r;
      reg         may_init_r;
      reg         bits8_r;

      wire req_mode  = (mode == `SPFC_MODE_MULTIDROP) || (mode == `SPFC_MODE_PERIPH) ||
                       (mode == `SPFC_MODE_SHARE) || (mode == `SPFC_MODE_MODBUS) ||
                       (mode == `SPFC_MODE_RMODEM);
      wire pad_mode  = (mode == `SPFC_MODE_PEER) || (mode == `SPFC_MODE_NETLINK) ||
                       (mode == `SPFC_MODE_PWRMTR);
      wire tri_drv   = (drv == `SPFC_DRV_FOUR_WIRE) || (drv == `SPFC_DRV_TWO_WIRE);
      wire rxoff_drv = (drv == `SPFC_DRV_HALF_DUP) || (drv == `SPFC_DRV_TWO_WIRE);
      // Delay source depends on mode
      wire [15:0] dly_sel = (mode == `SPFC_MODE_RMODEM) ? mdm_dly_r : dly_pad_r; // [R5] [R6]
      // Floor at the minimum pad count
      wire [15:0] pad_lim = (dly_pad_r < `SPFC_PAD_MIN) ? `SPFC_PAD_MIN : dly_pad_r; // [R11] [R12]

      // Configuration registers; statistics are read-only
      always @(posedge mclk_i) begin
        if (!reset_n_i) begin
          mdm_dly_r <= `SPFC_RST_MDM_DLY;
          dly_pad_r <= `SPFC_RST_DLY_PAD;
        end else if (reg_wr_i) begin
          if (reg_addr_i == a_mdm) begin
            mdm_dly_r <= reg_wdata_i;
          end
          if (reg_addr_i == a_pad) begin
            dly_pad_r <= reg_wdata_i;
          end
        end
      end

      // Pin synchroniser; level accepted once stages two and three agree
      always @(posedge mclk_i) begin
        if (!reset_n_i) begin
          cts_s1_r  <= 1'b0;
          cts_s2_r  <= 1'b0;
          cts_s3_r  <= 1'b0;
          cts_lvl_r <= 1'b0;
        end else begin
          cts_s1_r <= cts_pin_i[g];
          cts_s2_r <= cts_s1_r;
          cts_s3_r <= cts_s2_r;
          if (cts_s2_r == cts_s3_r) begin
            cts_lvl_r <= cts_s3_r;
          end
        end
      end

      // Post-rise delay; a drop of clear-to-send or entry to a request mode restarts it
      always @(posedge mclk_i) begin
        if (!reset_n_i) begin
          req_mode_d_r <= 1'b0;
          dly_cnt_r    <= 17'h00000;
          cts_ready_r  <= 1'b0;
        end else begin
          req_mode_d_r <= req_mode;
          if (!cts_lvl_r || (req_mode && !req_mode_d_r)) begin
            dly_cnt_r   <= 17'h00000;
            cts_ready_r <= 1'b0; // [R2]
          end else if (!req_mode) begin
            cts_ready_r <= 1'b1; // [R1]
          end else if ((dly_sel == 16'h0000) || (dly_cnt_r > {1'b0, dly_sel})) begin
            // Divider phase unknown; one extra tick keeps the wait no shorter than set
            cts_ready_r <= 1'b1; // [R4]
          end else if (tick_w) begin
            dly_cnt_r <= dly_cnt_r + 17'h00001; // [R4]
          end
        end
      end

      // Gate only moves between characters so a started one finishes
      always @(posedge mclk_i) begin
        if (!reset_n_i) begin
          tx_en_r <= 1'b0;
        end else if (tx_idle_i[g]) begin
          tx_en_r <= cts_ready_r; // [R20]
        end
      end

      // Fresh ready too: a gate kept through a long character may be stale
      assign tx_start_o[g] = tx_pending_i[g] & tx_idle_i[g] & tx_en_r & cts_ready_r; // [R1] [R2]
      assign tx_oe_o[g]    = ~tri_drv | cts_lvl_r; // [R19]
      assign rx_en_o[g]    = ~(rxoff_drv & ~tx_idle_i[g]);

      // Request-to-send per mode family
      always @(posedge mclk_i) begin
        if (!reset_n_i) begin
          rts_r <= 1'b0;
        end else if (req_mode) begin
          rts_r <= tx_pending_i[g] | ~tx_idle_i[g]; // [R8] [R9]
        end else begin
          rts_r <= ~rx_backlog_i[g]; // [R7] [R3]
        end
      end

      assign rts_pin_o[g] = rts_r;

      // Reply wait: one pad per character time, ENQ when the count runs out
      always @(posedge mclk_i) begin
        if (!reset_n_i) begin
          pad_st_r  <= PAD_IDLE;
          pad_cnt_r <= 16'h0000;
          pad_r     <= 1'b0;
          enq_r     <= 1'b0;
          stat_r    <= `SPFC_RST_STAT;
        end else begin
          pad_r <= 1'b0;
          enq_r <= 1'b0;
          case (pad_st_r)
            PAD_IDLE: begin
              if (reply_wait_i[g] && pad_mode) begin
                pad_st_r  <= PAD_WAIT; // [R10]
                pad_cnt_r <= 16'h0000;
              end
            end
            PAD_WAIT: begin
              if (!pad_mode) begin
                pad_st_r <= PAD_IDLE; // [R10]
              end else if (ack_rx_i[g]) begin
                stat_r   <= pad_cnt_r; // [R13]
                pad_st_r <= PAD_IDLE;
              end else if (char_tick_i[g]) begin
                if (pad_cnt_r >= pad_lim) begin
                  enq_r    <= 1'b1; // [R10]
                  pad_st_r <= PAD_IDLE;
                end else begin
                  pad_r     <= 1'b1; // [R21]
                  pad_cnt_r <= pad_cnt_r + 16'h0001;
                end
              end
            end
            default: begin
              pad_st_r <= PAD_IDLE;
            end
          endcase
        end
      end

      assign pad_send_o[g] = pad_r;
      assign enq_send_o[g] = enq_r;

      // Route length, master role and character width checks
      always @(posedge mclk_i) begin
        if (!reset_n_i) begin
          route_ok_r <= 1'b1;
          may_init_r <= 1'b0;
          bits8_r    <= 1'b1;
        end else begin
          route_ok_r <= (route_len_i[4*g+3:4*g] <= `SPFC_ROUTE_MAX); // [R15] [R16]
          may_init_r <= (mode != `SPFC_MODE_MODBUS) | mb_master_i[g]; // [R17]
          if (mode == `SPFC_MODE_MODBUS) begin
            bits8_r <= binary_framing_i[g]; // [R18]
          end else begin
            bits8_r <= data_bits8_i[g];
          end
        end
      end

      assign route_ok_o[g]     = route_ok_r;
      assign may_initiate_o[g] = may_init_r;
      assign char_bits8_o[g]   = bits8_r;
      assign mdm_dly_w[g]      = mdm_dly_r;
      assign dly_pad_w[g]      = dly_pad_r;
      assign stat_w[g]         = stat_r;
    end
  endgenerate

  // Registered read; unmapped numbers read as zero
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SPFC_REG_P1_STAT:    reg_rdata_o <= stat_w[0]; // [R13]
        `SPFC_REG_P2_STAT:    reg_rdata_o <= stat_w[1]; // [R13]
        `SPFC_REG_P1_MDM_DLY: reg_rdata_o <= mdm_dly_w[0];
        `SPFC_REG_P1_DLY_PAD: reg_rdata_o <= dly_pad_w[0];
        `SPFC_REG_P2_MDM_DLY: reg_rdata_o <= mdm_dly_w[1];
        `SPFC_REG_P2_DLY_PAD: reg_rdata_o <= dly_pad_w[1];
        default:              reg_rdata_o <= 16'h0000;
      endcase
    end
  end

endmodule
